// [core/ast_pkg.sv]
// Constants, register map and carrier types of the serial transmitter.
// Assumes an APB master with 32-bit data and one 25 MHz clock.
// Overview of operation
// - Line idles at mark, NRZ bit levels.
// - Frame: start, eight/nine data, stop bits.
// - Every bit lasts one baud period.
// - Eight-bit baud divisor and counter set timing.
// - Data bits leave least significant first.
// - Transmit path independent, shares format and rate.
// - No hardware parity; ninth bit from software.
// - Shift register loads only from transmit buffer.
// - Port enable forces transmit pin output.
// - Port enable forces receive pin input.
// - Enabling transmitter sets buffer empty flag unless a character is queued.
// - Buffer write starts send; idle shifter loads.
// - Queued character loads after previous stop bit.
// - Start bit begins right after transfer.
// - Empty flag clear only while queued or transmitter disabled.
// - Empty flag valid from second cycle after write.
// - Empty flag read-only to software.
// - Interrupt is flag gated by enable.
package ast_pkg;
  localparam logic [7:0] OFS_INTF = 8'h00;
  localparam logic [7:0] OFS_INTE = 8'h04;
  localparam logic [7:0] OFS_RCST = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  localparam logic [7:0] OFS_PIN_DIRECTION_BIT = 8'h10;
  localparam logic [7:0] OFS_TXB  = 8'h14;
  localparam logic [7:0] OFS_TXST = 8'h18;
  localparam logic [7:0] RST_TXST = 8'h02;
  localparam logic [7:0] RST_PIN_DIRECTION_BIT = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int BIT_TRANSMIT_BUFFER_EMPTY_FLAG  = 4;
  localparam int BIT_TRANSMIT_INTERRUPT_ENABLE  = 4;
  localparam int BIT_SERIAL_PORT_ENABLE  = 7;
  localparam int BIT_TX9   = 6;
  localparam int BIT_TRANSMIT_ENABLE  = 5;
  localparam int BIT_SYNC  = 4;
  localparam int BIT_HIGH_BAUD_SELECT  = 2;
  localparam int BIT_SHIFT_REGISTER_EMPTY  = 1;
  localparam int BIT_NINTH_TRANSMIT_BIT  = 0;
  localparam int PIN_TX    = 6;
  localparam int PIN_RX    = 7;
  localparam int SHIFT_W   = 11;
  typedef struct packed {
    logic       transmit_buffer_empty_flag;
    logic       busy;
    logic       queued;
  } ast_stat_t;
endpackage

// [core/ast_tx.sv]
// Asynchronous serial transmitter with APB register slave.
// Assumes one clock; the receive pin is sampled through three flops.
`timescale 1ns/100ps
module ast_tx #(
  parameter int DIV_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        receive_pin_i,
  output logic             transmit_pin_o,
  output logic             transmit_pin_oe_o,
  output logic             receive_pin_oe_o,
  output logic             irq_o
);
  logic [7:0]         txst_r;
  logic [7:0]         rcst_r;
  logic [7:0]         inte_r;
  logic [DIV_W-1:0]   baud_r;
  logic [7:0]         pin_direction_bit_r;
  logic [8:0]         txbuf_r;
  logic               queued_r;
  logic [ast_pkg::SHIFT_W-1:0] tsr_r;
  logic [3:0]         bits_r;
  logic               busy_r;
  logic [DIV_W-1:0]   cnt_r;
  logic               tick;
  logic               transmit_buffer_empty_flag;
  logic               wr;
  logic               acc;
  logic               load;
  logic               last_bit;
  logic [2:0]         rx_sync_r;
  logic               rx_lvl_r;
  logic [31:0]        rd_nxt;
  logic               err_nxt;
  logic [DIV_W-1:0]   gap_r;
  ast_pkg::ast_stat_t stat;

  assign acc = psel_i & penable_i & ~pready_o;
  assign wr  = acc & pwrite_i;
  assign transmit_buffer_empty_flag = txst_r[ast_pkg::BIT_TRANSMIT_ENABLE] & ~queued_r;
  assign last_bit = busy_r & tick & (bits_r == 4'h1);
  assign load = queued_r & (~busy_r | last_bit);
  assign stat = '{transmit_buffer_empty_flag: transmit_buffer_empty_flag, busy: busy_r, queued: queued_r};

  // Control registers; the empty flag and shifter status are not stored.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      txst_r <= ast_pkg::RST_TXST;
      rcst_r <= ast_pkg::RST_ZERO;
      inte_r <= ast_pkg::RST_ZERO;
      baud_r <= '0;
      pin_direction_bit_r <= ast_pkg::RST_PIN_DIRECTION_BIT;
    end
    else if (wr)
    begin
      case (paddr_i)
        ast_pkg::OFS_TXST: txst_r <= {pwdata_i[7:4], 1'b0,
                                      pwdata_i[2], 1'b0, pwdata_i[0]};
        ast_pkg::OFS_RCST: rcst_r <= pwdata_i[7:0];
        ast_pkg::OFS_INTE: inte_r <= pwdata_i[7:0];
        ast_pkg::OFS_BAUD: baud_r <= pwdata_i[DIV_W-1:0];
        ast_pkg::OFS_PIN_DIRECTION_BIT: pin_direction_bit_r <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Transmit buffer: a write queues, a transfer to the shifter empties.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      txbuf_r  <= '0;
      queued_r <= 1'b0;
    end
    else if (wr && paddr_i == ast_pkg::OFS_TXB)
    begin
      txbuf_r  <= {txst_r[ast_pkg::BIT_NINTH_TRANSMIT_BIT], pwdata_i[7:0]};
      queued_r <= 1'b1;
    end
    else if (load)
      queued_r <= 1'b0;
  end

  // Baud counter reloads from the divisor and ticks on expiry.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      cnt_r <= '0;
    else if (load || cnt_r == '0)
      cnt_r <= baud_r;
    else
      cnt_r <= cnt_r - 1'b1;
  end
  assign tick = (cnt_r == '0);

  // Shift register: start, data LSB first, optional ninth, stop.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tsr_r  <= '1;
      bits_r <= 4'h0;
      busy_r <= 1'b0;
    end
    else if (load)
    begin
      tsr_r  <= txst_r[ast_pkg::BIT_TX9] ? {1'b1, txbuf_r, 1'b0}
                                         : {2'b11, txbuf_r[7:0], 1'b0};
      bits_r <= txst_r[ast_pkg::BIT_TX9] ? 4'hB : 4'hA;
      busy_r <= 1'b1;
    end
    else if (busy_r && tick)
    begin
      tsr_r  <= {1'b1, tsr_r[ast_pkg::SHIFT_W-1:1]};
      bits_r <= bits_r - 4'h1;
      busy_r <= (bits_r != 4'h1);
    end
  end

  // Line level: mark while idle, NRZ level of the current bit otherwise.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      transmit_pin_o <= 1'b1;
    else
      transmit_pin_o <= busy_r ? tsr_r[0] : 1'b1;
  end

  // The port enable overrides the direction bit of the transmit pin.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      transmit_pin_oe_o <= 1'b0;
    else
      transmit_pin_oe_o <= rcst_r[ast_pkg::BIT_SERIAL_PORT_ENABLE] |
                           ~pin_direction_bit_r[ast_pkg::PIN_TX];
  end

  // The port enable keeps the port latch off the receive pin.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      receive_pin_oe_o <= 1'b0;
    else
      receive_pin_oe_o <= ~rcst_r[ast_pkg::BIT_SERIAL_PORT_ENABLE] &
                          ~pin_direction_bit_r[ast_pkg::PIN_RX];
  end

  // Interrupt request is the empty flag gated by its enable.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      irq_o <= 1'b0;
    else
      irq_o <= transmit_buffer_empty_flag & inte_r[ast_pkg::BIT_TRANSMIT_INTERRUPT_ENABLE];
  end

  // Receive pin passes three flops; the path is otherwise independent.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      rx_sync_r <= 3'h7;
    else
      rx_sync_r <= {rx_sync_r[1:0], receive_pin_i};
  end

  // A new level counts once the second and third flops agree.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      rx_lvl_r <= 1'b1;
    else if (rx_sync_r[2] == rx_sync_r[1])
      rx_lvl_r <= rx_sync_r[2];
  end

  // Clocks since the last bit boundary, so bit length can be checked.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      gap_r <= '0;
    else if (load || tick)
      gap_r <= '0;
    else
      gap_r <= gap_r + 1'b1;
  end

  always_comb
  begin
    rd_nxt  = '0;
    err_nxt = 1'b0;
    case (paddr_i)
      ast_pkg::OFS_INTF: rd_nxt[ast_pkg::BIT_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
      ast_pkg::OFS_INTE: rd_nxt[7:0] = inte_r;
      ast_pkg::OFS_RCST: rd_nxt[7:0] = rcst_r;
      ast_pkg::OFS_BAUD: rd_nxt[DIV_W-1:0] = baud_r;
      ast_pkg::OFS_PIN_DIRECTION_BIT: rd_nxt[7:0] = pin_direction_bit_r;
      ast_pkg::OFS_TXB:  rd_nxt = '0;
      ast_pkg::OFS_TXST:
      begin
        rd_nxt[7:0] = txst_r;
        rd_nxt[ast_pkg::BIT_SHIFT_REGISTER_EMPTY] = ~busy_r;
      end
      default: err_nxt = 1'b1;
    endcase
    rd_nxt[ast_pkg::PIN_RX + 8] = (paddr_i == ast_pkg::OFS_PIN_DIRECTION_BIT) &
                                  rx_lvl_r;
  end

  // APB: one wait state; ready pulses in the second access cycle.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= acc;
      prdata_o  <= acc ? rd_nxt : 32'h0000_0000;
      pslverr_o <= acc & err_nxt;
    end
  end

  // Line level and frame shape.
  a_idle_mark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !busy_r |=> transmit_pin_o)
    else $error("Line not at mark while idle.");

  a_idle_ones: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !busy_r |-> tsr_r == '1)
    else $error("Idle shifter not all mark.");

  a_start_space: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load |=> ##1 !transmit_pin_o)
    else $error("Start bit not space after load.");

  a_stop_mark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    last_bit |-> tsr_r[0])
    else $error("Stop bit not at mark.");

  a_no_parity: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load && !txst_r[ast_pkg::BIT_TX9] |=> tsr_r[9])
    else $error("Eight-bit frame has no stop after data.");

  a_lsb_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    busy_r && tick && bits_r > 4'h1 |=> tsr_r[0] == $past(tsr_r[1]))
    else $error("Shift not LSB first.");

  a_load_src: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load |=> tsr_r[8:1] == $past(txbuf_r[7:0]))
    else $error("Shifter not loaded from buffer.");

  a_busy_bits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !busy_r |-> bits_r == 4'h0)
    else $error("Bit count left over when idle.");

  a_bits_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bits_r <= 4'hB)
    else $error("Bit count beyond frame length.");

  // Bit timing.
  a_tick_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tick && !load |=> cnt_r == $past(baud_r))
    else $error("Counter did not reload.");

  a_bit_period: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    busy_r && tick |-> gap_r == baud_r)
    else $error("Bit did not last one baud period.");

  // Buffer, queue and empty flag.
  a_idle_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr && paddr_i == ast_pkg::OFS_TXB && !busy_r |=> ##1 busy_r)
    else $error("Idle shifter did not load.");

  a_load_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    load |=> busy_r)
    else $error("Load did not start the shifter.");

  a_queue_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stat.queued && stat.busy && !last_bit |=> stat.queued)
    else $error("Queued character left before stop bit.");

  a_queue_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    queued_r && last_bit |=> busy_r)
    else $error("Queued character not loaded after stop.");

  a_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !transmit_buffer_empty_flag && txst_r[ast_pkg::BIT_TRANSMIT_ENABLE] |-> queued_r && (busy_r || load))
    else $error("Empty flag clear without busy and queued.");

  a_enable_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(txst_r[ast_pkg::BIT_TRANSMIT_ENABLE]) && !queued_r |-> transmit_buffer_empty_flag)
    else $error("Flag not set on enable.");

  a_flag_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr && paddr_i == ast_pkg::OFS_TXB && busy_r && bits_r > 4'h2 &&
    txst_r[ast_pkg::BIT_TRANSMIT_ENABLE] |=> ##1 !transmit_buffer_empty_flag)
    else $error("Empty flag not clear two cycles after write.");

  a_flag_ro: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr && paddr_i == ast_pkg::OFS_INTF && !load |=>
    queued_r == $past(queued_r))
    else $error("Software write changed the empty flag.");

  // Interrupt request.
  a_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 irq_o == $past(transmit_buffer_empty_flag & inte_r[ast_pkg::BIT_TRANSMIT_INTERRUPT_ENABLE]))
    else $error("Interrupt not gated flag.");

  a_irq_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    transmit_buffer_empty_flag && inte_r[ast_pkg::BIT_TRANSMIT_INTERRUPT_ENABLE] |=> irq_o)
    else $error("Interrupt missing with flag and enable.");

  a_irq_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !inte_r[ast_pkg::BIT_TRANSMIT_INTERRUPT_ENABLE] |=> !irq_o)
    else $error("Interrupt raised while disabled.");

  // Pin directions.
  a_serial_port_enable_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rcst_r[ast_pkg::BIT_SERIAL_PORT_ENABLE] |=> transmit_pin_oe_o && !receive_pin_oe_o)
    else $error("Port enable did not set directions.");

  a_tx_oe_pin_direction_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !rcst_r[ast_pkg::BIT_SERIAL_PORT_ENABLE] |=>
    transmit_pin_oe_o == !$past(pin_direction_bit_r[ast_pkg::PIN_TX]))
    else $error("Transmit pin direction wrong without port enable.");

  a_rx_oe_pin_direction_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !rcst_r[ast_pkg::BIT_SERIAL_PORT_ENABLE] |=>
    receive_pin_oe_o == !$past(pin_direction_bit_r[ast_pkg::PIN_RX]))
    else $error("Receive pin direction wrong without port enable.");

  // Register slave handshake.
  a_ready_acc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc |=> pready_o)
    else $error("Access not answered.");

  a_ready_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !acc |=> !pready_o)
    else $error("Ready without an access.");

  a_ready_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pready_o |=> !pready_o)
    else $error("Ready held longer than one cycle.");

  a_err_ready: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pslverr_o |-> pready_o)
    else $error("Error response without ready.");

  a_err_mapped: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc && paddr_i == ast_pkg::OFS_TXST |=> !pslverr_o)
    else $error("Error on a mapped register.");

  a_rdata_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !pready_o |-> prdata_o == 32'h0000_0000)
    else $error("Read data not zero outside ready.");

  a_buf_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc && !pwrite_i && paddr_i == ast_pkg::OFS_TXB |=>
    prdata_o == 32'h0000_0000)
    else $error("Transmit buffer read returned data.");

endmodule // ast_tx

// [sim/ast_rx_model.sv]
// Remote asynchronous receiver model that decodes the serial line.
// Assumes the line is registered on clk_i and idles at mark.
`timescale 1ns/100ps
module ast_rx_model (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic [7:0] div_i,
  input  wire logic       nine_i,
  output logic            rx_line_o,
  output logic [8:0]      data_o,
  output logic [7:0]      frames_o,
  output logic            stop_err_o
);
  int i;
  initial
  begin
    rx_line_o = 1'b1;
    data_o = 9'h000;
    frames_o = 8'h00;
    stop_err_o = 1'b0;
  end
  // Samples each bit in its middle, one divisor+1 clock period apart.
  always
  begin
    @(negedge line_i);
    repeat ((div_i + 1) / 2) @(posedge clk_i);
    if (line_i !== 1'b0) stop_err_o = 1'b1;
    data_o = 9'h000;
    for (i = 0; i < (nine_i ? 9 : 8); i++)
    begin
      repeat (div_i + 1) @(posedge clk_i);
      data_o[i] = line_i;
    end
    repeat (div_i + 1) @(posedge clk_i);
    if (line_i !== 1'b1) stop_err_o = 1'b1;
    frames_o = frames_o + 8'h01;
  end
endmodule // ast_rx_model

// [sim/tb.sv]
// Testbench of the serial transmitter: APB tasks and line decoding.
// Assumes the receiver model decodes what the transmit pin sends.
`timescale 1ns/100ps
module tb;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, slverr, ready, tx, tx_oe, rx_oe, irq, rxl;
  logic        nine = 1'b0, serr;
  logic [7:0]  paddr = 8'h00, frames;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [8:0]  rdat;
  int          bad_count = 0, samples_checked = 0;
  always #20 clk_i = ~clk_i;
  ast_tx dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(ready), .pslverr_o(slverr),
    .receive_pin_i(rxl), .transmit_pin_o(tx), .transmit_pin_oe_o(tx_oe),
    .receive_pin_oe_o(rx_oe), .irq_o(irq));
  ast_rx_model rxm (.clk_i(clk_i), .line_i(tx), .div_i(8'h03),
    .nine_i(nine), .rx_line_o(rxl), .data_o(rdat), .frames_o(frames),
    .stop_err_o(serr));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int t;
    @(posedge clk_i);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (ready !== 1'b1 && t < 50);
    if (ready !== 1'b1)
      bad_count++;
    q = prdata;
    e = slverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & 32'h0000_00FF, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic frame(input logic [8:0] x);
    logic [7:0] f;
    int         t;
    f = frames;
    t = 0;
    while (frames === f && t < 2000)
    begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 2000)
      bad_count++;
    chk({23'h0, rdat}, {23'h0, x});
    chk({31'h0, serr}, 32'h0);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(8'h18, 32'h02, 1'b0);
    rd(8'h10, 32'hFF, 1'b0);
    rd(8'h00, 32'h00, 1'b0);
    rd(8'h0C, 32'h00, 1'b0);
    rd(8'h40, 32'h00, 1'b1);
    $display("test reset done");
    wr(8'h08, 32'h80);
    wr(8'h0C, 32'h03);
    wr(8'h18, 32'h20);
    chk({30'h0, tx_oe, rx_oe}, 32'h2);
    rd(8'h00, 32'h10, 1'b0);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h10, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h04, 32'h10);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h1);
    $display("test enable done");
    wr(8'h14, 32'hA5);
    wr(8'h14, 32'h3C);
    rd(8'h00, 32'h00, 1'b0);
    chk({31'h0, irq}, 32'h0);
    frame(9'h0A5);
    rd(8'h00, 32'h10, 1'b0);
    frame(9'h03C);
    repeat (8) @(posedge clk_i);
    rd(8'h18, 32'h22, 1'b0);
    $display("test queue done");
    nine <= 1'b1;
    wr(8'h18, 32'h61);
    wr(8'h14, 32'h81);
    wr(8'h04, 32'h00);
    frame(9'h181);
    repeat (8) @(posedge clk_i);
    chk({31'h0, tx}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test nine done");
    finish_test;
  end
endmodule // tb
